// ==== src/xbr_readahead.sv ====
module xbr_readahead
  import xbr_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_sys_rst,
  input  wire logic              i_ce,
  input  wire logic              i_cfg_we,
  input  wire logic              i_cfg_chan,
  input  wire logic [1:0]        i_cfg_size,
  input  wire logic [ADDR_W-1:0] i_cfg_addr,
  input  wire logic              i_start,
  input  wire logic              i_stop,
  input  wire logic              i_read_channel_select,
  input  wire logic [CNT_W-1:0]  i_item_count,
  output logic      [CNT_W-1:0]  o_ch0_remain,
  output logic      [CNT_W-1:0]  o_ch1_remain,
  input  wire logic              i_rd_pop,
  output logic      [DATA_W-1:0] o_rd_data,
  output logic                   o_rd_valid,
  output logic      [RF_CW-1:0]  o_rd_avail,
  input  wire logic              i_cre_rd_req,
  input  wire logic              i_cre_wr_req,
  input  wire logic [CS_W-1:0]   i_chip_select_target,
  input  wire logic [DATA_W-1:0] i_psram_config_value,
  output logic                   o_cre_rd_en,
  output logic      [DATA_W-1:0] o_cre_value,
  input  wire logic              i_wr_valid,
  input  wire logic [ADDR_W-1:0] i_wr_addr,
  input  wire logic [DATA_W-1:0] i_wr_data,
  output logic                   o_wr_stall,
  output logic      [WF_CW-1:0]  o_wr_free,
  output logic                   o_mem_req,
  output logic                   o_mem_we,
  output logic                   o_mem_cre,
  output logic      [CS_W-1:0]   o_mem_cs,
  output logic      [ADDR_W-1:0] o_mem_addr,
  output logic      [1:0]        o_mem_size,
  output logic      [DATA_W-1:0] o_mem_wdata,
  input  wire logic              i_mem_ack,
  input  wire logic [DATA_W-1:0] i_mem_rdata
);
  typedef struct packed {
    xbr_state_e                  st;
    logic                        rr;
    logic                        act;
    logic [1:0][ADDR_W-1:0]      addr;
    logic [1:0][1:0]             size;
    logic [1:0][CNT_W-1:0]       remain;
    logic                        cre_busy;
    logic                        cre_wr_pend;
    logic [CS_W-1:0]             cre_cs;
    logic [DATA_W-1:0]           cre_wval;
    logic [DATA_W-1:0]           cre_value;
    logic                        mem_req;
    logic                        mem_we;
    logic                        mem_cre;
    logic [CS_W-1:0]             mem_cs;
    logic [ADDR_W-1:0]           mem_addr;
    logic [1:0]                  mem_size;
    logic [DATA_W-1:0]           mem_wdata;
    logic [DATA_W-1:0]           rd_data;
    logic                        rd_valid;
  } xbr_top_s;

  localparam xbr_top_s TOP_RST = '{st: ST_IDLE, rr: 1'h0, act: 1'h0,
    addr: {ADDR_RST, ADDR_RST}, size: {SIZE_RST, SIZE_RST}, remain: '0,
    cre_busy: 1'h0, cre_wr_pend: 1'h0, cre_cs: '0, cre_wval: '0, cre_value: '0,
    mem_req: 1'h0, mem_we: 1'h0, mem_cre: 1'h0, mem_cs: '0, mem_addr: '0,
    mem_size: '0, mem_wdata: '0, rd_data: '0, rd_valid: 1'h0};

  xbr_top_s q;
  xbr_top_s d;
  logic     rpush;
  logic     rpop;
  logic     wpop;

  xbr_fifo_if #(.W(DATA_W), .CW(RF_CW)) rf ();
  xbr_fifo_if #(.W(WF_W), .CW(WF_CW))   wf ();

  // Read FIFO filled by the fetch engine and drained by the core.
  xbr_fifo #(.W(DATA_W), .DEPTH(RF_DEPTH), .CW(RF_CW)) u_rd_fifo (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_ce      (i_ce),
    .io        (rf)
  );

  // Write transaction FIFO filled by the core and drained to memory.
  xbr_fifo #(.W(WF_W), .DEPTH(WF_DEPTH), .CW(WF_CW)) u_wr_fifo (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_ce      (i_ce),
    .io        (wf)
  );

  // FIFO strobes; a write is taken only when a slot is free.
  assign rf.push  = rpush;
  assign rf.wdata = i_mem_rdata & xbr_mask(q.size[q.act]);
  assign rf.pop   = rpop;
  assign wf.push  = i_wr_valid;
  assign wf.wdata = {i_wr_addr, i_wr_data};
  assign wf.pop   = wpop;

  // Every output is a register of this block or of a FIFO.
  assign o_ch0_remain = q.remain[0];
  assign o_ch1_remain = q.remain[1];
  assign o_rd_data    = q.rd_data;
  assign o_rd_valid   = q.rd_valid;
  assign o_rd_avail   = rf.count;
  assign o_cre_rd_en  = q.cre_busy;
  assign o_cre_value  = q.cre_value;
  assign o_wr_stall   = wf.full;
  assign o_wr_free    = wf.free;
  assign o_mem_req    = q.mem_req;
  assign o_mem_we     = q.mem_we;
  assign o_mem_cre    = q.mem_cre;
  assign o_mem_cs     = q.mem_cs;
  assign o_mem_addr   = q.mem_addr;
  assign o_mem_size   = q.mem_size;
  assign o_mem_wdata  = q.mem_wdata;

  // Next state: core pops, access arbitration, then command updates.
  always_comb begin
    logic ch;
    ch    = (q.remain[q.rr] == '0) ? ~q.rr : q.rr;
    d     = q;
    rpush = 1'h0;
    rpop  = 1'h0;
    wpop  = 1'h0;
    d.rd_valid = 1'h0;
    if (i_rd_pop && !rf.empty) begin
      rpop       = 1'h1;
      d.rd_data  = rf.rdata;
      d.rd_valid = 1'h1;
    end
    case (q.st)
      ST_IDLE: begin
        d.mem_size = SIZE_32;
        d.mem_we   = 1'h0;
        d.mem_cre  = 1'h0;
        d.mem_cs   = DATA_CS;
        if (q.cre_busy) begin
          d.st      = ST_CRE_RD;
          d.mem_req = 1'h1;
          d.mem_cre = 1'h1;
          d.mem_cs  = q.cre_cs;
        end else if (q.cre_wr_pend) begin
          d.st        = ST_CRE_WR;
          d.mem_req   = 1'h1;
          d.mem_we    = 1'h1;
          d.mem_cre   = 1'h1;
          d.mem_cs    = q.cre_cs;
          d.mem_wdata = q.cre_wval;
        end else if (!wf.empty) begin
          wpop        = 1'h1;
          d.st        = ST_WRITE;
          d.mem_req   = 1'h1;
          d.mem_we    = 1'h1;
          d.mem_addr  = wf.rdata[WF_W-1:DATA_W];
          d.mem_wdata = wf.rdata[DATA_W-1:0];
        end else if (q.remain[ch] != '0 && !rf.full) begin
          d.st       = ST_FETCH;
          d.act      = ch;
          d.rr       = ~ch;
          d.mem_req  = 1'h1;
          d.mem_addr = q.addr[ch];
          d.mem_size = q.size[ch];
        end
      end
      ST_FETCH: begin
        if (i_mem_ack) begin
          rpush          = 1'h1;
          d.st           = ST_IDLE;
          d.mem_req      = 1'h0;
          d.addr[q.act]  = q.addr[q.act] + xbr_step(q.size[q.act]);
          if (q.remain[q.act] != '0) begin
            d.remain[q.act] = CNT_W'(q.remain[q.act] - 1'h1);
          end
        end
      end
      ST_CRE_RD: begin
        if (i_mem_ack) begin
          d.st        = ST_IDLE;
          d.mem_req   = 1'h0;
          d.cre_value = i_mem_rdata;
          d.cre_busy  = 1'h0;
        end
      end
      ST_CRE_WR: begin
        if (i_mem_ack) begin
          d.st          = ST_IDLE;
          d.mem_req     = 1'h0;
          d.cre_wr_pend = 1'h0;
        end
      end
      ST_WRITE: begin
        if (i_mem_ack) begin
          d.st      = ST_IDLE;
          d.mem_req = 1'h0;
        end
      end
      default: begin
        d.st      = ST_IDLE;
        d.mem_req = 1'h0;
      end
    endcase
    // Channel setup overrides the address that the fetch engine advances after each item.
    if (i_cfg_we) begin
      d.addr[i_cfg_chan] = i_cfg_addr;
      d.size[i_cfg_chan] = i_cfg_size;
    end
    // Commands come after the engine update so a start or stop overrides the engine.
    if (i_start) begin
      d.remain[i_read_channel_select] = i_item_count;
    end
    if (i_stop) begin
      d.remain[i_read_channel_select] = '0;
    end
    // Config requests are accepted only while no config access pends.
    if (!q.cre_busy && !q.cre_wr_pend) begin
      if (i_cre_rd_req) begin
        d.cre_busy = 1'h1;
        d.cre_cs   = i_chip_select_target;
      end else if (i_cre_wr_req) begin
        d.cre_wr_pend = 1'h1;
        d.cre_cs      = i_chip_select_target;
        d.cre_wval    = i_psram_config_value;
      end
    end
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      q <= TOP_RST;
    end else if (i_ce) begin
      q <= d;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  sequence idle_free_s;
    i_ce && q.st == ST_IDLE && !q.cre_busy && !q.cre_wr_pend && wf.empty;
  endsequence

  fetch_launch_a: assert property (
    (idle_free_s and (!rf.full && q.remain != '0)) |=> (q.st == ST_FETCH) && o_mem_req)
    else $error("pending items with FIFO room did not launch a fetch");
  full_pause_a: assert property (
    (idle_free_s and rf.full) |=> (q.st != ST_FETCH) && !o_mem_req)
    else $error("fetch launched into a full read FIFO");
  count_load_a: assert property (
    (i_ce && i_start && !i_stop) |=>
      q.remain[$past(i_read_channel_select)] == $past(i_item_count))
    else $error("start did not load the item count");
  stop_cancel_a: assert property (
    (i_ce && i_stop) |=> q.remain[$past(i_read_channel_select)] == '0)
    else $error("stop left items outstanding");
  addr_advance_a: assert property (
    (i_ce && q.st == ST_FETCH && i_mem_ack && !i_cfg_we) |=>
      q.addr[$past(q.act)] == $past(q.addr[q.act]) + xbr_step($past(q.size[q.act])))
    else $error("fetch address did not advance by one item");
  cre_rd_hold_a: assert property (
    (i_ce && i_cre_rd_req && !o_cre_rd_en && !q.cre_wr_pend) |=> o_cre_rd_en)
    else $error("config read enable did not rise on a read request");
  cre_rd_keep_a: assert property (
    (i_ce && o_cre_rd_en && !(q.st == ST_CRE_RD && i_mem_ack)) |=> o_cre_rd_en)
    else $error("config read enable dropped before the answer");
  cre_capture_a: assert property (
    (i_ce && q.st == ST_CRE_RD && i_mem_ack) |=>
      !o_cre_rd_en && o_cre_value == $past(i_mem_rdata))
    else $error("config value not captured at the read answer");
  cre_strobe_a: assert property (
    (q.st == ST_CRE_WR) |-> o_mem_req && o_mem_we && o_mem_cre)
    else $error("config write without its enable strobe");
  pop_one_a: assert property (
    (i_ce && i_rd_pop && !rf.empty && !rpush) |=>
      o_rd_valid && o_rd_avail == RF_CW'($past(o_rd_avail) - 1'h1))
    else $error("read FIFO pop did not remove exactly one item");

  fifo_full_pause_c: cover property (idle_free_s and (rf.full && q.remain != '0));
  cre_read_done_c:   cover property (q.st == ST_CRE_RD ##1 !o_cre_rd_en);
  stop_midway_c:     cover property (i_stop && q.remain[i_read_channel_select] > 12'h001);
  write_stall_c:     cover property (o_wr_stall && i_wr_valid);
endmodule

// ==== src/xbr_pkg.sv ====
package xbr_pkg;
  // Widths of the external address, data word and item counter.
  localparam int unsigned ADDR_W   = 24;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned CNT_W    = 12;
  localparam int unsigned CS_W     = 2;
  // Read FIFO and write transaction FIFO geometry.
  localparam int unsigned RF_DEPTH = 8;
  localparam int unsigned RF_CW    = 4;
  localparam int unsigned WF_DEPTH = 4;
  localparam int unsigned WF_CW    = 3;
  localparam int unsigned WF_W     = ADDR_W + DATA_W;
  // Item width encodings.
  localparam logic [1:0] SIZE_8    = 2'h0;
  localparam logic [1:0] SIZE_16   = 2'h1;
  localparam logic [1:0] SIZE_32   = 2'h2;
  // Values after reset and the chip select used by data traffic.
  localparam logic [ADDR_W-1:0] ADDR_RST = 24'h000000;
  localparam logic [1:0]        SIZE_RST = SIZE_8;
  localparam logic [CS_W-1:0]   DATA_CS  = 2'h0;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FETCH,
    ST_WRITE,
    ST_CRE_RD,
    ST_CRE_WR
  } xbr_state_e;

  // Address advance for one item of the given width.
  function automatic logic [ADDR_W-1:0] xbr_step(input logic [1:0] sz);
    case (sz)
      SIZE_16: xbr_step = 24'h000002;
      SIZE_32: xbr_step = 24'h000004;
      default: xbr_step = 24'h000001;
    endcase
  endfunction

  // Keeps only the bits that belong to an item of the given width.
  function automatic logic [DATA_W-1:0] xbr_mask(input logic [1:0] sz);
    case (sz)
      SIZE_16: xbr_mask = 32'h0000FFFF;
      SIZE_32: xbr_mask = 32'hFFFFFFFF;
      default: xbr_mask = 32'h000000FF;
    endcase
  endfunction
endpackage

// ==== src/xbr_fifo_if.sv ====
interface xbr_fifo_if #(
  parameter int unsigned W  = 32,
  parameter int unsigned CW = 4
);
  logic          push;
  logic [W-1:0]  wdata;
  logic          pop;
  logic [W-1:0]  rdata;
  logic [CW-1:0] count;
  logic [CW-1:0] free;
  logic          full;
  logic          empty;

  modport store (input push, input wdata, input pop,
                 output rdata, output count, output free, output full, output empty);
  modport user  (output push, output wdata, output pop,
                 input rdata, input count, input free, input full, input empty);
endinterface

// ==== src/xbr_fifo.sv ====
module xbr_fifo
  import xbr_pkg::*;
#(
  parameter int unsigned W     = 32,
  parameter int unsigned DEPTH = 8,
  parameter int unsigned CW    = 4
) (
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_ce,
  xbr_fifo_if.store io
);
  localparam int unsigned PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wp;
    logic [PW-1:0]           rp;
    logic [CW-1:0]           cnt;
    logic [CW-1:0]           free;
    logic                    full;
    logic                    empty;
  } xbr_fifo_s;

  localparam xbr_fifo_s FIFO_RST = '{mem: '0, wp: '0, rp: '0, cnt: '0,
                                     free: CW'(DEPTH), full: 1'h0, empty: 1'h1};

  xbr_fifo_s q;
  xbr_fifo_s d;

  // Head, fill level and flags all come from registers.
  assign io.rdata = q.mem[q.rp];
  assign io.count = q.cnt;
  assign io.free  = q.free;
  assign io.full  = q.full;
  assign io.empty = q.empty;

  // A push into a full store and a pop from an empty one are ignored.
  always_comb begin
    logic do_push;
    logic do_pop;
    do_push = io.push && !q.full;
    do_pop  = io.pop && !q.empty;
    d = q;
    if (do_push) begin
      d.mem[q.wp] = io.wdata;
      d.wp        = PW'(q.wp + 1'h1);
    end
    if (do_pop) begin
      d.rp = PW'(q.rp + 1'h1);
    end
    d.cnt   = CW'(q.cnt + CW'(do_push) - CW'(do_pop));
    d.free  = CW'(CW'(DEPTH) - d.cnt);
    d.full  = (d.cnt == CW'(DEPTH));
    d.empty = (d.cnt == '0);
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      q <= FIFO_RST;
    end else if (i_ce) begin
      q <= d;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  free_slot_count_a: assert property (
    (io.free + io.count) == CW'(DEPTH))
    else $error("free slots and fill level do not add up to depth");
  full_push_held_a: assert property (
    (i_ce && q.full && io.push && !io.pop) |=> (q.cnt == $past(q.cnt)) && q.full)
    else $error("push into a full store changed its level");
endmodule

// ==== verification/xbr_mem_model.sv ====
module xbr_mem_model
  import xbr_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_sys_rst,
  input  wire logic [7:0]        i_delay,
  input  wire logic              i_req,
  input  wire logic              i_we,
  input  wire logic              i_cre,
  input  wire logic [CS_W-1:0]   i_cs,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wdata,
  output logic                   o_ack,
  output logic      [DATA_W-1:0] o_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]        wait_q;
  logic [DATA_W-1:0] cre_q [4];

  // Answers each request after i_delay waiting cycles; read data toggles outside the answer.
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_ack   <= 1'b0;
      o_rdata <= 32'h00000000;
      wait_q  <= 8'h00;
    end else if (o_ack) begin
      o_ack   <= 1'b0;
      o_rdata <= ~o_rdata;
    end else if (i_req && wait_q >= i_delay) begin
      o_ack   <= 1'b1;
      wait_q  <= 8'h00;
      if (i_cre && i_we) begin
        cre_q[i_cs] <= i_wdata;
      end
      o_rdata <= i_cre ? cre_q[i_cs] : {8'h5A, i_addr};
    end else begin
      wait_q  <= i_req ? wait_q + 8'h01 : 8'h00;
      o_rdata <= ~o_rdata;
    end
  end
endmodule

// ==== verification/tb.sv ====
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin errors++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end

module tb
  import xbr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk, rst, cfg_we, cfg_chan, start, stop, chan, pop, cre_rd, cre_wr;
  logic              wr_valid, rd_valid, cre_rd_en, wr_stall, mem_req, mem_we, mem_cre, mem_ack;
  logic [1:0]        cfg_size, mem_size;
  logic [CS_W-1:0]   cs, mem_cs;
  logic [ADDR_W-1:0] cfg_addr, wr_addr, mem_addr;
  logic [CNT_W-1:0]  count, remain0, remain1;
  logic [DATA_W-1:0] cre_val, rd_data, cre_value, wr_data, mem_wdata, mem_rdata;
  logic [RF_CW-1:0]  rd_avail;
  logic [WF_CW-1:0]  wr_free;
  logic [7:0]        delay;
  int                errors, samples_checked;

  xbr_readahead xbr_readahead_inst (
    .i_clk(clk), .i_sys_rst(rst), .i_ce(1'b1), .i_cfg_we(cfg_we), .i_cfg_chan(cfg_chan),
    .i_cfg_size(cfg_size), .i_cfg_addr(cfg_addr), .i_start(start), .i_stop(stop),
    .i_read_channel_select(chan), .i_item_count(count), .o_ch0_remain(remain0),
    .o_ch1_remain(remain1), .i_rd_pop(pop), .o_rd_data(rd_data), .o_rd_valid(rd_valid),
    .o_rd_avail(rd_avail), .i_cre_rd_req(cre_rd), .i_cre_wr_req(cre_wr),
    .i_chip_select_target(cs), .i_psram_config_value(cre_val), .o_cre_rd_en(cre_rd_en),
    .o_cre_value(cre_value), .i_wr_valid(wr_valid), .i_wr_addr(wr_addr), .i_wr_data(wr_data),
    .o_wr_stall(wr_stall), .o_wr_free(wr_free), .o_mem_req(mem_req), .o_mem_we(mem_we),
    .o_mem_cre(mem_cre), .o_mem_cs(mem_cs), .o_mem_addr(mem_addr), .o_mem_size(mem_size),
    .o_mem_wdata(mem_wdata), .i_mem_ack(mem_ack), .i_mem_rdata(mem_rdata));

  xbr_mem_model xbr_mem_model_inst (
    .i_clk(clk), .i_sys_rst(rst), .i_delay(delay), .i_req(mem_req), .i_we(mem_we),
    .i_cre(mem_cre), .i_cs(mem_cs), .i_addr(mem_addr), .i_wdata(mem_wdata), .o_ack(mem_ack),
    .o_rdata(mem_rdata));

  // The clock toggles every 5 ns, a period of 10 ns.
  always #5 clk = ~clk;

  // All stimulus changes 1 ns after the rising edge.
  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  // Expected item: the memory answers with a marker byte above the address.
  function automatic logic [DATA_W-1:0] item(input logic [ADDR_W-1:0] a, input logic [1:0] s);
    item = {8'h5A, a};
    if (s == SIZE_16) item = item & 32'h0000FFFF;
    else if (s != SIZE_32) item = item & 32'h000000FF;
  endfunction

  function automatic logic [ADDR_W-1:0] step(input logic [1:0] s);
    step = (s == SIZE_16) ? 24'h000002 : (s == SIZE_32) ? 24'h000004 : 24'h000001;
  endfunction

  task automatic setup(input logic c, input logic [1:0] s, input logic [ADDR_W-1:0] a);
    {cfg_we, cfg_chan, cfg_size, cfg_addr} = {1'b1, c, s, a};
    tick();
    cfg_we = 1'b0;
  endtask

  task automatic go(input logic c, input logic [CNT_W-1:0] n);
    {start, chan, count} = {1'b1, c, n};
    tick();
    start = 1'b0;
    `CHK("remain", n, c ? remain1 : remain0)
  endtask

  // Waits for an item, takes it and compares it.
  task automatic pop_one(input logic [DATA_W-1:0] ex);
    for (int n = 0; n < 3000 && rd_avail == 4'h0; n++) tick();
    pop = 1'b1;
    tick();
    pop = 1'b0;
    `CHK("rd_valid", 1'b1, rd_valid)
    `CHK("rd_data", ex, rd_data)
    // One edge passes so that the next pop is a fresh strobe.
    tick();
  endtask

  task automatic drain(input logic [ADDR_W-1:0] a, input logic [1:0] s, input int n);
    for (int i = 0; i < n; i++) pop_one(item(a + step(s) * ADDR_W'(i), s));
  endtask

  task automatic t_reset();
    `CHK("wr_free", 3'h4, wr_free)
    `CHK("rd_avail", 4'h0, rd_avail)
    `CHK("mem_req", 1'b0, mem_req)
    $display("reset test done");
  endtask

  // Exact counts and address continuation on channel 0, every width on channel 1.
  task automatic t_stream();
    delay = 8'h00;
    setup(1'b0, SIZE_8, 24'h000010);
    go(1'b0, 12'h003);
    drain(24'h000010, SIZE_8, 3);
    repeat (10) tick();
    `CHK("rd_avail", 4'h0, rd_avail)
    `CHK("remain0", 12'h000, remain0)
    go(1'b0, 12'h002);
    drain(24'h000013, SIZE_8, 2);
    for (int s = 0; s < 3; s++) begin
      setup(1'b1, 2'(s), 24'h000100 + 24'(s * 64));
      go(1'b1, 12'h002);
      drain(24'h000100 + 24'(s * 64), 2'(s), 2);
    end
    $display("stream test done");
  endtask

  // Fetching pauses with a full read FIFO and resumes as it drains.
  task automatic t_full();
    setup(1'b0, SIZE_32, 24'h000200);
    go(1'b0, 12'h00A);
    for (int n = 0; n < 500 && rd_avail != 4'h8; n++) tick();
    repeat (20) tick();
    `CHK("rd_avail", 4'h8, rd_avail)
    `CHK("remain0", 12'h002, remain0)
    `CHK("mem_req", 1'b0, mem_req)
    pop_one(item(24'h000200, SIZE_32));
    `CHK("rd_avail", 4'h7, rd_avail)
    drain(24'h000204, SIZE_32, 9);
    `CHK("remain0", 12'h000, remain0)
    $display("full test done");
  endtask

  // A stop on the largest count ends fetching for that channel.
  task automatic t_stop();
    int n;
    delay = 8'h05;
    setup(1'b1, SIZE_16, 24'h000400);
    go(1'b1, 12'hFFF);
    for (int k = 0; k < 500 && rd_avail < 4'h2; k++) tick();
    {stop, chan} = 2'b11;
    tick();
    stop = 1'b0;
    repeat (30) tick();
    `CHK("remain1", 12'h000, remain1)
    n = int'(rd_avail);
    repeat (20) tick();
    `CHK("rd_avail", RF_CW'(n), rd_avail)
    drain(24'h000400, SIZE_16, n);
    $display("stop test done");
  endtask

  // Configuration writes to every chip select, then reads back in reverse order.
  // The parent interface is taken to be in its 16-bit host-bus mode already.
  task automatic t_cre();
    logic [3:0] rc;
    delay = 8'h03;
    for (int c = 0; c < 4; c++) begin
      {cs, cre_val, cre_wr} = {2'(c), 32'hC0DE0000 + 32'(c), 1'b1};
      tick();
      cre_wr = 1'b0;
      for (int n = 0; n < 100 && !mem_req; n++) tick();
      `CHK("cre_strobe", 1'b1, mem_cre & mem_we)
      `CHK("cre_cs", cs, mem_cs)
      `CHK("cre_wdata", cre_val, mem_wdata)
      for (int n = 0; n < 100 && mem_req; n++) tick();
    end
    for (int c = 3; c >= 0; c--) begin
      {cs, cre_rd, rc} = {2'(c), 1'b1, 4'h0};
      tick();
      cre_rd = 1'b0;
      `CHK("cre_rd_en", 1'b1, cre_rd_en)
      for (int n = 0; n < 100 && cre_rd_en; n++) begin
        if (mem_req) rc = {mem_cre, mem_we, mem_cs};
        tick();
      end
      `CHK("cre_access", {2'b10, 2'(c)}, rc)
      `CHK("cre_value", 32'hC0DE0000 + 32'(c), cre_value)
    end
    $display("config test done");
  endtask

  // Writes against a slow memory until the write FIFO refuses.
  task automatic t_wr();
    delay = 8'h14;
    {wr_valid, wr_addr, wr_data} = {1'b1, 24'h000020, 32'h11110000};
    tick();
    `CHK("wr_free", 3'h3, wr_free)
    for (int i = 1; i < 8 && !wr_stall; i++) begin
      {wr_addr, wr_data} = {24'(i), 32'h11110000 + 32'(i)};
      tick();
    end
    {wr_addr, wr_data} = {24'h0000FF, 32'h2222FFFF};
    repeat (5) tick();
    `CHK("wr_access", {1'b1, 1'b1, 1'b0, DATA_CS, SIZE_32, 24'h000020, 32'h11110000}, {mem_req, mem_we, mem_cre, mem_cs, mem_size, mem_addr, mem_wdata})
    `CHK("wr_stall", 1'b1, wr_stall)
    `CHK("wr_free", 3'h0, wr_free)
    for (int n = 0; n < 500 && wr_stall; n++) tick();
    tick();
    wr_valid = 1'b0;
    for (int n = 0; n < 500 && wr_free != 3'h4; n++) tick();
    `CHK("wr_free", 3'h4, wr_free)
    $display("write test done");
  endtask

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Main sequence: reset for ten cycles, then each scenario in turn.
  initial begin
    {clk, rst, cfg_we, cfg_chan, start, stop, chan, pop, cre_rd, cre_wr, wr_valid} = 11'h200;
    {cfg_size, cs, cfg_addr, wr_addr, count, delay} = '0;
    {cre_val, wr_data} = '0;
    repeat (10) @(posedge clk);
    #1;
    rst = 1'b0;
    tick();
    t_reset();
    t_stream();
    t_full();
    t_stop();
    t_cre();
    t_wr();
    conclude();
  end

  // Watchdog: the scenarios need a few thousand cycles at most.
  initial begin
    #200000;
    errors++;
    conclude();
  end
endmodule
